// ---- hw/pts_pkg.sv ----
// Constants shared by the PCM time slot assigner.
package pts_pkg;
    // ==========================================================
    // Serial control word layout
    localparam int WORD_BITS = 8;
    localparam logic [3:0] WORD_BITS_C = 4'h8;
    localparam int SEND_DIR_POS = 7;
    localparam int INC_DIR_POS = 6;
    localparam int SLOT_OFF_POS = 5;
    localparam int SLOT_W = 6;
    // ==========================================================
    // Frame timing
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [SLOT_W-1:0] SLOT_LIMIT = 6'h20;
    localparam int CHANNELS = 4;
    localparam int ENTRIES = 8;
    // ==========================================================
    // Register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
    localparam int CTRL_EN_POS = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int STATUS_MODE_POS = 8;
    // ==========================================================
    // Synchroniser input bit positions
    localparam int SYNC_W = 10;
    localparam int S_BCLK = 3;
    localparam int S_SEND = 4;
    localparam int S_INC = 5;
    localparam int S_CCLK = 6;
    localparam int S_CSEL = 7;
    localparam int S_CDAT = 8;
    localparam int S_MODE = 9;
endpackage

// ---- hw/pts_assigner.sv ----
// PCM time slot assigner with serial control port and APB status.
//
// Operation
// - Every assignment is one eight-bit serial control word.
// - Two direction bits pick send, incoming, both or neither group in separate mode; single-sync only checks for both set.
// - Six-bit field holds slot number 0 to 31.
// - Each slot pulse is high for exactly one slot of eight bit clocks.
// - Frames of up to 32 slots, length set by frame start spacing.
// - Mode pin high selects separate mode, low selects single-sync mode.
// - Separate mode times incoming outputs from incoming start, send from send start.
// - Separate mode uses two channel picks for channels 0 to 3.
// - Single-sync mode times all eight outputs from send start only.
// - Single-sync mode uses three channel picks for eight outputs.
// - After reset all slot and send active outputs stay low until assigned.
// - Data sampled on control clock falling edges while select is low.
// - Select rising edge copies the word into the chosen assignment.
// - New assignment applies from the next complete slot.
// - Send counter clears on first bit clock fall after start, steps every eight.
// - Send count compared with four send assignments, all eight in single-sync; match pulses output.
// - Incoming counter likewise starts slot zero and pulses incoming outputs in separate mode.
// - Send direction bit first, then incoming bit, then slot bits MSB first.
// - Slot MSB set makes the output inactive.
// - Open-drain send active pulls low during send pulses, any pulse in single-sync.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pts_assigner
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [pts_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bclk,
    input wire logic send_frame_start,
    input wire logic incoming_frame_start,
    input wire logic ctl_clk,
    input wire logic ctl_data,
    input wire logic ctl_sel_n,
    input wire logic [2:0] channel_pick,
    input wire logic mode_separate,
    output logic [3:0] send_slot_pulse,
    output logic [3:0] incoming_slot_pulse,
    output logic send_active_out,
    output logic send_active_oe
);
    import pts_pkg::*;

    // ==========================================================
    // Input synchronisers
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] prev;
    assign raw_in = {mode_separate, ctl_data, ctl_sel_n, ctl_clk, incoming_frame_start,
                     send_frame_start, bclk, channel_pick};

    // Two flops per pin, plus a third stage used only for edge detection.
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++)
        begin : gen_sync
            // Select and mode idle high, so their stages reset high and no false edge follows.
            localparam logic IDLE_LVL = (g == S_CSEL) || (g == S_MODE);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1[g] <= IDLE_LVL;
                    sync2[g] <= IDLE_LVL;
                    prev[g] <= IDLE_LVL;
                end
                else
                begin
                    sync1[g] <= raw_in[g];
                    sync2[g] <= sync1[g];
                    prev[g] <= sync2[g];
                end
            end
        end
    endgenerate

    // Edge and level decode of the synchronised pins.
    wire mode_sep = sync2[S_MODE];
    wire [2:0] pick = sync2[2:0];
    wire bclk_fall = prev[S_BCLK] & ~sync2[S_BCLK];
    wire cclk_fall = prev[S_CCLK] & ~sync2[S_CCLK];
    wire sel_rise = ~prev[S_CSEL] & sync2[S_CSEL];
    wire sel_low = ~sync2[S_CSEL];
    wire [1:0] start_rise = sync2[S_INC:S_SEND] & ~prev[S_INC:S_SEND];

    // ==========================================================
    // Serial control port
    logic [WORD_BITS-1:0] shift;
    logic [3:0] bit_cnt;

    // Falling control clock shifts data while select is low; select high restarts.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift <= '0;
            bit_cnt <= 4'h0;
        end
        else if (!sel_low)
            bit_cnt <= 4'h0;
        else if (cclk_fall && bit_cnt != WORD_BITS_C)
        begin
            shift <= {shift[WORD_BITS-2:0], sync2[S_CDAT]};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // A full word ends by select rising; short words are dropped, bits after the eighth are ignored.
    wire commit = sel_rise && bit_cnt == WORD_BITS_C;
    wire send_n = shift[SEND_DIR_POS];
    wire inc_n = shift[INC_DIR_POS];
    wire [SLOT_W-1:0] new_slot = shift[SLOT_W-1:0];

    // ==========================================================
    // Send and incoming slot counters
    logic [1:0] armed;
    logic [1:0] live;
    logic [2:0] bit_pos [2];
    logic [SLOT_W-1:0] slot_cnt [2];
    wire [1:0] bound;

    generate
        for (g = 0; g < 2; g++)
        begin : gen_cnt
            wire restart = bclk_fall && (armed[g] || start_rise[g]);
            // Slot boundary: frame restart or eighth bit clock of a slot.
            assign bound[g] = restart || (bclk_fall && bit_pos[g] == LAST_BIT);
            // Counter clears on the first falling bit clock after start rises.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    armed[g] <= 1'b0;
                    live[g] <= 1'b0;
                    bit_pos[g] <= 3'h0;
                    slot_cnt[g] <= SLOT_LIMIT;
                end
                else if (restart)
                begin
                    armed[g] <= 1'b0;
                    live[g] <= 1'b1;
                    bit_pos[g] <= 3'h0;
                    slot_cnt[g] <= '0;
                end
                else
                begin
                    armed[g] <= armed[g] | start_rise[g];
                    if (bclk_fall)
                    begin
                        bit_pos[g] <= bit_pos[g] + 3'h1;
                        if (bit_pos[g] == LAST_BIT && slot_cnt[g] != SLOT_LIMIT)
                            slot_cnt[g] <= slot_cnt[g] + 6'h01;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Assignment entries: 0..3 send group, 4..7 incoming group.
    logic [ENTRIES-1:0] pend_on;
    logic [SLOT_W-1:0] pend_slot [ENTRIES];
    logic [ENTRIES-1:0] live_on;
    logic [SLOT_W-1:0] live_slot [ENTRIES];
    logic [ENTRIES-1:0] pulse;
    logic out_en;

    generate
        for (g = 0; g < ENTRIES; g++)
        begin : gen_entry
            // Entry select and timing source per mode.
            wire sel1 = mode_sep && pick[1:0] == 2'(g % CHANNELS);
            wire wr1 = sel1 && (g < CHANNELS ? !send_n : !inc_n);
            wire off1 = sel1 && send_n && inc_n;
            wire sel2 = !mode_sep && pick == 3'(g);
            wire wr2 = sel2 && !(send_n && inc_n);
            wire off2 = sel2 && send_n && inc_n;
            wire use_send = (g < CHANNELS) || !mode_sep;
            wire src = use_send ? 1'b0 : 1'b1;
            wire hit = live[src] && slot_cnt[src] == live_slot[g];

            // Pending copy on commit, live copy taken at the next slot boundary.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pend_on[g] <= 1'b0;
                    pend_slot[g] <= '0;
                    live_on[g] <= 1'b0;
                    live_slot[g] <= '0;
                    pulse[g] <= 1'b0;
                end
                else
                begin
                    if (commit && (wr1 || wr2))
                    begin
                        pend_on[g] <= !new_slot[SLOT_OFF_POS];
                        pend_slot[g] <= new_slot;
                    end
                    else if (commit && (off1 || off2))
                        pend_on[g] <= 1'b0;
                    if (bound[src])
                    begin
                        live_on[g] <= pend_on[g];
                        live_slot[g] <= pend_slot[g];
                    end
                    pulse[g] <= out_en && live_on[g] && hit;
                end
            end
        end
    endgenerate

    assign send_slot_pulse = pulse[CHANNELS-1:0];
    assign incoming_slot_pulse = pulse[ENTRIES-1:CHANNELS];

    // Open-drain send active: driven low while a send-counted pulse is out.
    assign send_active_out = 1'b0;
    assign send_active_oe = mode_sep ? |send_slot_pulse : |pulse;

    // ==========================================================
    // APB slave: control and status words, zero-wait.
    wire setup = psel && !penable;
    wire hit_ctrl = paddr == CTRL_ADDR;
    wire hit_stat = paddr == STATUS_ADDR;
    wire ctrl_wr = psel && penable && pwrite && hit_ctrl;
    wire [31:0] status_word = (32'(mode_sep) << STATUS_MODE_POS) | 32'(live_on);

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_ctrl && !hit_stat;

    // Read data captured in the setup phase; control written in access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            out_en <= CTRL_EN_RESET;
        end
        else
        begin
            if (setup)
                prdata <= hit_ctrl ? {31'h0, out_en} : (hit_stat ? status_word : 32'h0);
            if (ctrl_wr)
                out_en <= pwdata[CTRL_EN_POS];
        end
    end

    // ==========================================================
    // Assertions and cover points.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    pulse_needs_assign_a: assert property ((pulse & ~$past(live_on)) == 8'h00)
        else $error("Slot pulse without live assignment.");
    short_word_drop_a: assert property (sel_rise && bit_cnt != WORD_BITS_C |=>
        $stable(pend_on) && $stable(pend_slot[0]))
        else $error("Assignment changed by a short word.");
    shift_on_fall_a: assert property (cclk_fall && sel_low && bit_cnt < WORD_BITS_C |=>
        shift[0] == $past(sync2[S_CDAT]) && bit_cnt == $past(bit_cnt) + 4'h1)
        else $error("Control bit not shifted on falling clock.");
    counter_clear_a: assert property (bclk_fall && armed[0] |=>
        slot_cnt[0] == 6'h00 && bit_pos[0] == 3'h0)
        else $error("Send counter not cleared at frame start.");
    slot_step_a: assert property (bclk_fall && !armed[0] && !start_rise[0] &&
        bit_pos[0] == LAST_BIT && slot_cnt[0] < SLOT_LIMIT |=>
        slot_cnt[0] == $past(slot_cnt[0]) + 6'h01)
        else $error("Send slot counter did not step.");
    live_at_bound_a: assert property ($changed(live_on) |-> $past(|bound))
        else $error("Assignment took effect outside a slot boundary.");
    active_single_a: assert property (!mode_sep && |incoming_slot_pulse |-> send_active_oe)
        else $error("Send active not driven in single-sync mode.");
    disable_code_a: assert property (commit && send_n && inc_n && !mode_sep |=>
        !pend_on[$past(pick)])
        else $error("Disable code did not clear the entry.");
    pulse_edge_a: assert property ($changed(pulse) |->
        $past(bclk_fall, 2) || $past(ctrl_wr, 2) || $past(ctrl_wr) || $past(|bound) ||
        $past(bclk_fall) || ($past(mode_sep) != $past(mode_sep, 2)))
        else $error("Slot pulse changed away from a bit clock edge.");

    // A word whose slot flag is set may not turn any entry on.
    flag_keeps_off_a: assert property (commit && new_slot[SLOT_OFF_POS] |=>
        (pend_on & ~$past(pend_on)) == 8'h00)
        else $error("Slot flag enabled an entry.");

    // Main scenarios: commit, short word, pulses in both modes.
    word_commit_c: cover property (commit);
    word_drop_c: cover property (sel_rise && bit_cnt != WORD_BITS_C);
    send_pulse_c: cover property ($rose(send_slot_pulse[0]));
    sep_inc_c: cover property (mode_sep && $rose(incoming_slot_pulse[0]));
    single_inc_c: cover property (!mode_sep && $rose(incoming_slot_pulse[1]));
endmodule
`default_nettype wire

// ---- sim/pts_host_model.sv ----
// Host controller model that loads serial control words.
`timescale 1ns/100ps
`default_nettype none
module pts_host_model
(
    input wire logic pclk,
    output logic ctl_clk,
    output logic ctl_data,
    output logic ctl_sel_n,
    output logic [2:0] channel_pick
);
    // ==========================================================
    // Serial loader
    // Idle levels of the control port at time zero.
    initial
    begin
        ctl_clk = 1'b0;
        ctl_data = 1'b0;
        ctl_sel_n = 1'b1;
        channel_pick = 3'h0;
    end

    // Each level is held five pclk, above the synchroniser's three.
    task automatic hold();
        repeat (5) @(posedge pclk);
    endtask

    // Sends the top nb bits of w, leftmost first, to channel ch.
    task automatic load(input logic [2:0] ch, input logic [7:0] w, input int nb);
        ctl_data <= 1'b1;
        ctl_clk <= 1'b1;
        hold();
        ctl_clk <= 1'b0; // A fall while deselected must be ignored.
        hold();
        channel_pick <= ch;
        ctl_sel_n <= 1'b0;
        hold();
        for (int i = 0; i < nb; i++)
        begin
            ctl_clk <= 1'b1;
            ctl_data <= w[7 - i];
            hold();
            ctl_clk <= 1'b0;
            hold();
        end
        ctl_sel_n <= 1'b1;
        hold();
        ctl_data <= ~ctl_data; // The released line stops showing the last bit.
        channel_pick <= ~ch;
        hold();
    endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the PCM time slot assigner.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pts_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, bclk, mode_separate;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, send_frame_start, incoming_frame_start;
    logic ctl_clk, ctl_data, ctl_sel_n, send_active_out, send_active_oe;
    logic [2:0] channel_pick;
    logic [3:0] send_slot_pulse, incoming_slot_pulse;
    logic [5:0] exp_slot [8];
    logic chk_on = 1'b0;
    logic out_on = 1'b1;
    int n_fail = 0;
    int samples_checked = 0;
    int bcnt = 0;

    pts_assigner DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bclk(bclk),
        .send_frame_start(send_frame_start), .incoming_frame_start(incoming_frame_start),
        .ctl_clk(ctl_clk), .ctl_data(ctl_data), .ctl_sel_n(ctl_sel_n),
        .channel_pick(channel_pick), .mode_separate(mode_separate),
        .send_slot_pulse(send_slot_pulse), .incoming_slot_pulse(incoming_slot_pulse),
        .send_active_out(send_active_out), .send_active_oe(send_active_oe));
    pts_host_model host (.pclk(pclk), .ctl_clk(ctl_clk), .ctl_data(ctl_data),
        .ctl_sel_n(ctl_sel_n), .channel_pick(channel_pick));

    // ==========================================================
    // Clocks and frames
    // System clock of 10 ns.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Bit clock of 125 ns, offset so its edges never meet pclk edges.
    initial
    begin
        bclk = 1'b0;
        #2;
        forever #62.5 bclk = ~bclk;
    end
    // Frames of 64 bits; the incoming frame starts one slot later.
    always @(posedge pclk)
    begin
        send_frame_start <= (bcnt % 64 == 0);
        incoming_frame_start <= (bcnt % 64 == 8);
    end
    // Counts bit clocks and checks the slot and send active outputs once per bit.
    always @(posedge bclk)
    begin
        bcnt <= bcnt + 1;
        if (chk_on)
            chk_frame(bcnt + 1);
    end

    // ==========================================================
    // Tasks
    task automatic close_out();
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic chk_frame(input int b);
        logic [7:0] ev;
        int s;
        for (int i = 0; i < 8; i++)
        begin
            s = (i < 4 || !mode_separate) ? (b + 63) % 64 : (b + 55) % 64;
            ev[i] = out_on && !exp_slot[i][5] && exp_slot[i] == s / 8;
        end
        chk({22'h0, send_active_out, send_active_oe, incoming_slot_pulse, send_slot_pulse},
            {22'h0, 1'b0, mode_separate ? |ev[3:0] : |ev, ev});
    endtask

    // One APB transfer; read data and error flag are compared at the ready edge.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [31:0] want, input logic werr);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            n_fail++;
            close_out();
        end
        if (!wr)
            chk(prdata, want);
        chk({31'h0, pslverr}, {31'h0, werr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic stat();
        logic [7:0] en;
        for (int i = 0; i < 8; i++)
            en[i] = !exp_slot[i][5];
        apb(1'b0, STATUS_ADDR, 32'h0, {23'h0, mode_separate, en}, 1'b0);
    endtask

    task automatic ld(input logic [2:0] ch, input logic [1:0] code, input logic [5:0] sl,
        input int nb);
        host.load(ch, {code, sl}, nb);
        if (nb == 8 && !mode_separate)
            exp_slot[ch] = (code == 2'b11) ? 6'h20 : sl;
        else if (nb == 8)
        begin
            if (code != 2'b10)
                exp_slot[ch[1:0]] = (code == 2'b11) ? 6'h20 : sl;
            if (code != 2'b01)
                exp_slot[ch[1:0] + 4] = (code == 2'b11) ? 6'h20 : sl;
        end
    endtask

    task automatic frames(input int n);
        repeat (16) @(posedge bclk);
        chk_on <= 1'b1;
        repeat (n * 64) @(posedge bclk);
        chk_on <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic start(input logic md);
        presetn <= 1'b0;
        mode_separate <= md;
        for (int i = 0; i < 8; i++)
            exp_slot[i] = 6'h20;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, send_frame_start, incoming_frame_start} = 6'h00;
        mode_separate = 1'b1;
        paddr = '0;
        pwdata = 32'h0;
        @(posedge pclk);
        start(1'b1);
        apb(1'b0, CTRL_ADDR, 32'h0, 32'h1, 1'b0);
        stat();
        frames(1);
        apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
        apb(1'b1, CTRL_ADDR, 32'h0, 32'h0, 1'b0);
        apb(1'b0, CTRL_ADDR, 32'h0, 32'h0, 1'b0);
        apb(1'b1, CTRL_ADDR, 32'h1, 32'h0, 1'b0);
        ld(3'h0, 2'b10, 6'h05, 8);
        ld(3'h1, 2'b01, 6'h02, 8);
        ld(3'h2, 2'b00, 6'h03, 8);
        ld(3'h3, 2'b01, 6'h22, 8);
        ld(3'h0, 2'b01, 6'h0A, 8);
        ld(3'h3, 2'b10, 6'h00, 7);
        frames(2);
        stat();
        ld(3'h2, 2'b11, 6'h03, 8);
        frames(1);
        start(1'b0);
        stat();
        ld(3'h5, 2'b00, 6'h01, 8);
        ld(3'h0, 2'b10, 6'h04, 8);
        ld(3'h6, 2'b11, 6'h02, 8);
        ld(3'h3, 2'b01, 6'h07, 8);
        frames(2);
        stat();
        apb(1'b1, CTRL_ADDR, 32'h0, 32'h0, 1'b0);
        out_on = 1'b0;
        frames(1);
        close_out();
    end

    // Cuts a hung run short.
    initial
    begin
        #500000;
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
